// [hw/sea_consts.svh]
// constants of the serial eeprom access block
`ifndef SEA_CONSTS_SVH
`define SEA_CONSTS_SVH
`define SEA_OP_SR_WR 8'h01
`define SEA_OP_WRITE 8'h02
`define SEA_OP_READ 8'h03
`define SEA_OP_LATCH_CLR 8'h04
`define SEA_OP_SR_RD 8'h05
`define SEA_OP_LATCH_SET 8'h06
`define SEA_ADDR_W 14
`define SEA_PAGE_W 6
`define SEA_HI_W 6
`define SEA_MEM_WORDS 16384
`define SEA_GUARD_NONE 2'h0
`define SEA_GUARD_QTR 2'h1
`define SEA_GUARD_HALF 2'h2
`define SEA_GUARD_ALL 2'h3
`define SEA_QTR_TOP 2'h3
`define SEA_SR_LOCK 7
`define SEA_SR_G1 3
`define SEA_SR_G0 2
`define SEA_SR_LATCH 1
`define SEA_SR_BUSY 0
`define SEA_CLK_NS 5
`define SEA_PROG_TIME_NS 20000
`define SEA_PROG_CYCLES (`SEA_PROG_TIME_NS / `SEA_CLK_NS)
`define SEA_FIFO_DEPTH 4
`define SEA_SYNC_W 6
`define SEA_SYNC_IDLE 6'h26
`endif

// [hw/sea_pkg.sv]
// types shared by the serial eeprom access block
`include "sea_consts.svh"
package sea_pkg;
	typedef enum logic [2:0] {
		S_OPC, S_ADDR, S_READ, S_WDATA, S_SDATA, S_SREAD, S_TAIL, S_DEAD
	} sea_state_e;
	typedef struct packed {
		logic [`SEA_PAGE_W-1:0] off;
		logic [7:0]             data;
	} sea_wbyte_s;
	typedef struct packed {
		logic       lock;
		logic [1:0] guard;
		logic       latch;
		logic       busy;
	} sea_status_s;
endpackage

// [hw/sea_access.sv]
// serial eeprom command logic with page buffer fifo
// Behaviour
// - read loads received address into counter and shifts out that byte.
// - further read bytes advance the counter; after 3fffh it wraps to zero.
// - chip select high ends a read at any clock without side effects.
// - read command is refused while a program cycle runs.
// - two top address bits are ignored for read and write.
// - program starts only on deselect right after a whole data byte.
// - program completion clears busy flag and write latch.
// - up to 64 data bytes are buffered before programming on deselect.
// - only low six address bits increment; excess bytes wrap within page.
// - write refused without latch, while busy, or into guarded block.
// - write abandoned unless clock count is 24 plus 8 per byte.
// - guard bits: 00 none, 01 3000h up, 10 2000h up, 11 all.
// - status lock zero allows status writes when latch set.
// - lock set: status writes allowed with protect pin high, refused low.
// - protect pin high releases hardware guard, leaving only block guard.
// - guarded block never writable; status needs latch and no hardware guard.
// - paused: output floats, input and clock ignored; select stays low.
// - with clock low, pause follows the pause input at once.
// - with clock high, pause change waits until clock goes low.
// - deselect while paused ends the operation in progress.
// - low supply or power-on cancels pending writes and clears latch.
// - opcode msb first after select; read 03h, write 02h.
// - unknown opcode ignores remaining clocks until deselect.
// - latch set only by set command; cleared by clear command or program end.
`timescale 1ns/1ps
`default_nettype none
`include "sea_consts.svh"

module sea_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 4
) (
	input  wire logic         mclk,
	input  wire logic         rst,
	input  wire logic         inValid,
	input  wire logic [W-1:0] inData,
	input  wire logic         outReady,
	output logic              inReady,
	output logic              outValid,
	output logic      [W-1:0] outData
);
	// depth must be a power of two: pointers carry one wrap bit
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] memQ [DEPTH];
	logic [AW:0]  wrQ;
	logic [AW:0]  rdQ;
	wire  [AW:0]  level = wrQ - rdQ;
	wire          push  = inValid & inReady;
	wire          pop   = outValid & outReady;
	assign inReady  = level != (AW+1)'(DEPTH);
	assign outValid = level != '0;
	assign outData  = memQ[rdQ[AW-1:0]];
	always_ff @(posedge mclk) begin
		if (rst) begin
			wrQ <= '0;
			rdQ <= '0;
		end else begin
			if (push) wrQ <= wrQ + 1'b1;
			if (pop) rdQ <= rdQ + 1'b1;
		end
	end
	always_ff @(posedge mclk) begin
		if (push) memQ[wrQ[AW-1:0]] <= inData;
	end
endmodule

module sea_access import sea_pkg::*; #(
	parameter int PROG_CYCLES = `SEA_PROG_CYCLES,
	parameter int FIFO_DEPTH  = `SEA_FIFO_DEPTH
) (
	input  wire logic  mclk,
	input  wire logic  rst,
	input  wire logic  csN,
	input  wire logic  sck,
	input  wire logic  si,
	input  wire logic  wpN,
	input  wire logic  holdN,
	input  wire logic  lowSupply,
	output logic       soOut,
	output logic       soOe,
	output sea_status_s status,
	output logic       hwGuardMode
);
	localparam int AW = `SEA_ADDR_W;
	localparam int PW = `SEA_PAGE_W;
	localparam int CW = $clog2(PROG_CYCLES + 1);
	localparam logic [CW-1:0] PROG_LAST = CW'(PROG_CYCLES - 1);

	logic [`SEA_SYNC_W-1:0] syncAQ;
	logic [`SEA_SYNC_W-1:0] syncBQ;
	logic                   sckPrevQ;
	logic                   csPrevQ;
	logic                   pausedQ;
	sea_state_e             stateQ;
	sea_state_e             stateD;
	logic                   armedQ;
	logic                   armedD;
	logic [7:0]             shiftQ;
	logic [2:0]             bitCntQ;
	logic [7:0]             cmdQ;
	logic                   addrLoQ;
	logic [AW-1:0]          addrQ;
	logic [PW-1:0]          pageOffQ;
	logic [7:0]             outShiftQ;
	logic [2:0]             outBitQ;
	logic [7:0]             newSrQ;
	logic                   startPendQ;
	logic                   progMemQ;
	logic [CW-1:0]          progCntQ;
	logic [PW-1:0]          commitIdxQ;
	logic [(1<<PW)-1:0]     validQ;
	logic [7:0]             pageBuf [1<<PW];
	logic [7:0]             mem [`SEA_MEM_WORDS];
	logic [7:0]             statusByte;
	logic                   pushReady;
	logic                   drainValid;
	sea_wbyte_s             drainWord;

	// pins come from another clock domain: two flops before any use
	wire [`SEA_SYNC_W-1:0] pinsRaw = {csN, sck, si, wpN, holdN, lowSupply};
	wire csS  = syncBQ[5];
	wire sckS = syncBQ[4];
	wire siS  = syncBQ[3];
	wire wpS  = syncBQ[2];
	wire hldS = syncBQ[1];
	wire lowS = syncBQ[0];

	wire       sckRise  = sckS & ~sckPrevQ;
	wire       sckFall  = ~sckS & sckPrevQ;
	wire       active   = ~csS & ~pausedQ;
	wire       rise     = active & sckRise;
	wire       fall     = active & sckFall;
	wire [7:0] shiftIn  = {shiftQ[6:0], siS};
	wire       byteDone = rise & (bitCntQ == 3'h7);
	wire       busy     = status.busy;
	wire       latch    = status.latch;
	wire       hwGuard  = status.lock & ~wpS;
	wire [AW-1:0] fullAddr = {addrQ[AW-1:8], shiftIn};
	wire       isRead   = cmdQ == `SEA_OP_READ;
	wire       sending  = (stateQ == S_READ) | (stateQ == S_SREAD);
	wire [7:0] memRd    = mem[addrQ];
	wire [7:0] outByte  = (stateQ == S_READ) ? memRd : statusByte;
	wire       deselect = csS & ~csPrevQ;
	wire       commit   = deselect & armedQ & ~pausedQ & ~lowS;
	wire       progRun  = busy & ~startPendQ;
	wire       progEnd  = progRun & (progCntQ == PROG_LAST);
	wire       pushValid = byteDone & (stateQ == S_WDATA);
	wire       drainFire = drainValid & ~progRun;
	wire       qtrHit   = fullAddr[AW-1:AW-2] == `SEA_QTR_TOP;
	wire       halfHit  = fullAddr[AW-1];
	wire       guardHit = (status.guard == `SEA_GUARD_ALL)
		| ((status.guard == `SEA_GUARD_HALF) & halfHit)
		| ((status.guard == `SEA_GUARD_QTR) & qtrHit);
	wire       memCommit = progRun & progMemQ & validQ[commitIdxQ];
	wire [AW-1:0] commitAddr = {addrQ[AW-1:PW], commitIdxQ};
	wire       srWrite  = commit & (cmdQ == `SEA_OP_SR_WR);
	wire       memWrite = commit & (cmdQ == `SEA_OP_WRITE);
	// a refused write opcode during a program must not wipe the page being walked
	wire       wrOpc    = byteDone & (stateQ == S_OPC) & (shiftIn == `SEA_OP_WRITE) & ~busy;

	always_comb begin
		statusByte                = 8'h00;
		statusByte[`SEA_SR_LOCK]  = status.lock;
		statusByte[`SEA_SR_G1]    = status.guard[1];
		statusByte[`SEA_SR_G0]    = status.guard[0];
		statusByte[`SEA_SR_LATCH] = status.latch;
		statusByte[`SEA_SR_BUSY]  = status.busy;
	end

	// command sequencer; any extra clock disarms a pending commit
	always_comb begin
		stateD = stateQ;
		armedD = armedQ;
		if (csS | lowS) begin
			stateD = S_OPC;
			armedD = 1'b0;
		end else if (rise) begin
			armedD = 1'b0;
			case (stateQ)
				S_OPC: begin
					if (byteDone) begin
						case (shiftIn)
							`SEA_OP_READ: stateD = busy ? S_DEAD : S_ADDR;
							`SEA_OP_WRITE: stateD = (busy | ~latch) ? S_DEAD : S_ADDR;
							`SEA_OP_LATCH_SET, `SEA_OP_LATCH_CLR: begin
								stateD = S_TAIL;
								armedD = ~busy;
							end
							`SEA_OP_SR_WR: begin
								stateD = (busy | ~latch | hwGuard) ? S_DEAD : S_SDATA;
							end
							`SEA_OP_SR_RD: stateD = S_SREAD;
							default: stateD = S_DEAD;
						endcase
					end
				end
				S_ADDR: begin
					if (byteDone & addrLoQ) begin
						if (isRead) begin
							stateD = S_READ;
						end else begin
							stateD = guardHit ? S_DEAD : S_WDATA;
						end
					end
				end
				S_WDATA: armedD = byteDone & pushReady;
				S_SDATA: begin
					if (byteDone) begin
						stateD = S_TAIL;
						armedD = 1'b1;
					end
				end
				S_TAIL: stateD = S_DEAD;
				default: stateD = stateQ;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			// idle pin levels: no false clock edge or low-supply pulse after reset
			syncAQ   <= `SEA_SYNC_IDLE;
			syncBQ   <= `SEA_SYNC_IDLE;
			sckPrevQ <= 1'b0;
			csPrevQ  <= 1'b1;
			pausedQ  <= 1'b0;
			stateQ   <= S_OPC;
			armedQ   <= 1'b0;
		end else begin
			syncAQ   <= pinsRaw;
			syncBQ   <= syncAQ;
			sckPrevQ <= sckS;
			csPrevQ  <= csS;
			stateQ   <= stateD;
			armedQ   <= armedD;
			if (csS) begin
				pausedQ <= 1'b0;
			end else if (~sckS) begin
				pausedQ <= ~hldS;
			end
		end
	end

	// serial shifting and addressing
	always_ff @(posedge mclk) begin
		if (rst | csS) begin
			shiftQ  <= 8'h00;
			bitCntQ <= 3'h0;
			addrLoQ <= 1'b0;
			outBitQ <= 3'h0;
		end else if (rise) begin
			shiftQ  <= shiftIn;
			bitCntQ <= bitCntQ + 3'h1;
			if (byteDone & (stateQ == S_ADDR)) addrLoQ <= 1'b1;
		end else if (fall & sending) begin
			outBitQ <= outBitQ + 3'h1;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			cmdQ      <= 8'h00;
			addrQ     <= '0;
			pageOffQ  <= '0;
			outShiftQ <= 8'h00;
			newSrQ    <= 8'h00;
			soOut     <= 1'b0;
			soOe      <= 1'b0;
		end else begin
			soOe <= active & sending;
			if (byteDone & (stateQ == S_OPC)) cmdQ <= shiftIn;
			if (byteDone & (stateQ == S_SDATA)) newSrQ <= shiftIn;
			if (byteDone & (stateQ == S_ADDR)) begin
				if (~addrLoQ) begin
					addrQ[AW-1:8] <= shiftIn[`SEA_HI_W-1:0];
				end else begin
					addrQ[7:0] <= shiftIn;
					pageOffQ   <= shiftIn[PW-1:0];
				end
			end else if (pushValid & pushReady) begin
				pageOffQ <= pageOffQ + 1'b1;
			end else if (fall & sending) begin
				if (outBitQ == 3'h0) begin
					soOut     <= outByte[7];
					outShiftQ <= {outByte[6:0], 1'b0};
					if (stateQ == S_READ) addrQ <= addrQ + 1'b1;
				end else begin
					soOut     <= outShiftQ[7];
					outShiftQ <= {outShiftQ[6:0], 1'b0};
				end
			end
		end
	end

	// bytes pass the fifo into the page buffer; a full fifo drops the commit
	sea_fifo #(
		.W     ($bits(sea_wbyte_s)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.mclk     (mclk),
		.rst      (rst),
		.inValid  (pushValid),
		.inData   ({pageOffQ, shiftIn}),
		.outReady (~progRun),
		.inReady  (pushReady),
		.outValid (drainValid),
		.outData  (drainWord)
	);

	always_ff @(posedge mclk) begin
		if (drainFire) pageBuf[drainWord.off] <= drainWord.data;
	end

	always_ff @(posedge mclk) begin
		if (memCommit) mem[commitAddr] <= pageBuf[commitIdxQ];
	end

	// program cycle: waits for the fifo to drain, then walks the page
	always_ff @(posedge mclk) begin
		if (rst) begin
			status      <= '0;
			hwGuardMode <= 1'b0;
			startPendQ  <= 1'b0;
			progMemQ    <= 1'b0;
			progCntQ    <= '0;
			commitIdxQ  <= '0;
			validQ      <= '0;
		end else begin
			hwGuardMode <= hwGuard;
			if (progRun) begin
				progCntQ   <= progCntQ + 1'b1;
				commitIdxQ <= commitIdxQ + 1'b1;
			end
			if (startPendQ & ~drainValid) startPendQ <= 1'b0;
			if (drainFire) validQ[drainWord.off] <= 1'b1;
			if (wrOpc) validQ <= '0;
			if (lowS) begin
				status.busy  <= 1'b0;
				status.latch <= 1'b0;
				startPendQ   <= 1'b0;
				validQ       <= '0;
			end else if (progEnd) begin
				status.busy  <= 1'b0;
				status.latch <= 1'b0;
				validQ       <= '0;
				if (~progMemQ) begin
					status.lock  <= newSrQ[`SEA_SR_LOCK];
					status.guard <= {newSrQ[`SEA_SR_G1], newSrQ[`SEA_SR_G0]};
				end
			end else if (srWrite | memWrite) begin
				status.busy <= 1'b1;
				startPendQ  <= 1'b1;
				progMemQ    <= memWrite;
				progCntQ    <= '0;
				commitIdxQ  <= '0;
			end else if (commit & (cmdQ == `SEA_OP_LATCH_SET)) begin
				status.latch <= 1'b1;
			end else if (commit & (cmdQ == `SEA_OP_LATCH_CLR)) begin
				status.latch <= 1'b0;
			end
		end
	end

	a_read_busy_drop: assert property (
		@(posedge mclk) disable iff (rst)
		(stateQ == S_OPC) && byteDone && !csS && !lowS
			&& (shiftIn == `SEA_OP_READ) && busy |=> stateQ == S_DEAD)
		else $error("read accepted while busy");

	a_prog_end_latch: assert property (
		@(posedge mclk) disable iff (rst)
		$fell(status.busy) |-> !status.latch)
		else $error("latch left set after program");

	a_write_guarded: assert property (
		@(posedge mclk) disable iff (rst)
		(stateQ == S_WDATA) && ($past(stateQ) == S_ADDR) |-> latch && !busy)
		else $error("write accepted without latch or while busy");

	a_page_wrap: assert property (
		@(posedge mclk) disable iff (rst)
		pushValid && pushReady && !csS |=>
			pageOffQ == $past(pageOffQ) + 1'b1 && addrQ == $past(addrQ))
		else $error("page offset did not step within page");

	a_read_advance: assert property (
		@(posedge mclk) disable iff (rst)
		fall && (stateQ == S_READ) && (outBitQ == 3'h0) |=>
			addrQ == $past(addrQ) + 1'b1)
		else $error("read address did not advance");

	a_pause_float: assert property (
		@(posedge mclk) disable iff (rst)
		pausedQ |=> !soOe)
		else $error("output driven while paused");

	a_pause_follow: assert property (
		@(posedge mclk) disable iff (rst)
		!csS && !sckS |=> pausedQ == !$past(hldS))
		else $error("pause did not follow input with clock low");

	a_pause_defer: assert property (
		@(posedge mclk) disable iff (rst)
		!csS && sckS |=> $stable(pausedQ))
		else $error("pause changed with clock high");

	a_low_supply: assert property (
		@(posedge mclk) disable iff (rst)
		lowS |=> !status.latch && !status.busy && !startPendQ)
		else $error("low supply left a write pending");

	a_start_armed: assert property (
		@(posedge mclk) disable iff (rst)
		$rose(status.busy) |-> $past(armedQ) && $past(deselect))
		else $error("program started without clean deselect");
endmodule
`default_nettype wire

// [bench/sea_host.sv]
// serial host model driving the eeprom pins
`timescale 1ns/1ps
`default_nettype none
module sea_host (
	output logic      csN,
	output logic      sck,
	output logic      si,
	output logic      holdN,
	input  wire logic soOut,
	input  wire logic soOe
);
	logic [7:0] rx;
	logic       oeAny;
	initial begin
		csN = 1'b1;
		sck = 1'b0;
		si = 1'b0;
		holdN = 1'b1;
		rx = 8'h00;
		oeAny = 1'b0;
	end
	task automatic go();
		csN = 1'b0;
		oeAny = 1'b0;
		#30;
	endtask
	// mode 0 clocking, 48 ns period; clock rests low outside frames
	task automatic xb(input logic [7:0] v, input int n);
		for (int i = 0; i < n; i++) begin
			si = v[7-i];
			#24 sck = 1'b1;
			rx = {rx[6:0], soOut};
			oeAny |= soOe;
			#24 sck = 1'b0;
		end
	endtask
	// deselect before the next rising edge, so a whole command commits
	task automatic stop();
		#12 csN = 1'b1;
		si = ~si;
		#40;
	endtask
	// pause with clock low; clocks meanwhile must be ignored
	task automatic pause(input logic drop);
		holdN = 1'b0;
		#20;
		oeAny = 1'b0;
		for (int i = 0; i < 4; i++) begin
			si = ~si;
			#24 sck = 1'b1;
			oeAny |= soOe;
			#24 sck = 1'b0;
		end
		// keeping select low is the host's duty; drop breaks it on purpose
		if (drop) csN = 1'b1;
		#20 holdN = 1'b1;
		#20;
	endtask
endmodule
`default_nettype wire

// [bench/sea_access_tb.sv]
// self-checking bench of the serial eeprom access block
`timescale 1ns/1ps
`default_nettype none
module sea_access_tb import sea_pkg::*; ();
	localparam int PROG = 100;
	logic        mclk, rst, wpN, lowSupply, csN, sck, si, holdN;
	logic        soOut, soOe, hwGuardMode;
	sea_status_s status;
	int          mismatches = 0;
	int          cmpCount = 0;
	logic [7:0]  expQ[$];
	logic [7:0]  dat[66];
	logic [7:0]  pg[64];
	int          ad[4] = '{'h1fff, 'h2000, 'h2fff, 'h3000};
	int          lo[4] = '{'h4000, 'h3000, 'h2000, 0};
	event        got;
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	sea_access #(.PROG_CYCLES(PROG), .FIFO_DEPTH(4)) u_dut (
		.mclk(mclk), .rst(rst), .csN(csN), .sck(sck), .si(si), .wpN(wpN),
		.holdN(holdN), .lowSupply(lowSupply), .soOut(soOut), .soOe(soOe),
		.status(status), .hwGuardMode(hwGuardMode));
	sea_host u_host (.csN(csN), .sck(sck), .si(si), .holdN(holdN),
		.soOut(soOut), .soOe(soOe));
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		cmpCount++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask
	// every received byte is judged against the oldest note
	initial forever begin
		@(got);
		chk(u_host.rx, expQ.pop_front());
	end
	task automatic rd(input logic [7:0] e);
		expQ.push_back(e);
		u_host.xb(8'($urandom), 8);
		->got;
	endtask
	task automatic cmd(input logic [7:0] op, input logic [7:0] v = 8'h00, input bit two = 1'b0);
		u_host.go();
		u_host.xb(op, 8);
		if (two) u_host.xb(v, 8);
		u_host.stop();
	endtask
	// frame left open so the caller decides how it ends
	task automatic wr(input logic [15:0] a, input int n, input logic [7:0] op);
		u_host.go();
		u_host.xb(op, 8);
		u_host.xb(a[15:8], 8);
		u_host.xb(a[7:0], 8);
		for (int i = 0; i < n; i++) u_host.xb(dat[i], 8);
	endtask
	task automatic idle();
		for (int i = 0; i < 2 * PROG && status.busy !== 1'b0; i++) @(posedge mclk);
	endtask
	task automatic rdst(input logic [7:0] e);
		idle();
		u_host.go();
		u_host.xb(8'h05, 8);
		rd(e);
		u_host.stop();
	endtask
	task automatic pin(input logic v);
		@(posedge mclk);
		#1 wpN = v;
		repeat (4) @(posedge mclk);
	endtask
	task automatic tend(input string s);
		$display("test %s done", s);
	endtask
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", cmpCount, mismatches);
		if (mismatches == 0 && cmpCount > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// whole sequence needs roughly 150 us
	initial begin
		#400000;
		mismatches++;
		print_verdict();
	end
	initial begin
		rst = 1'b1;
		wpN = 1'b1;
		lowSupply = 1'b0;
		void'($urandom(32'hba88));
		repeat (3) @(posedge mclk);
		#1 rst = 1'b0;
		repeat (4) @(posedge mclk);
		chk({2'b00, status, hwGuardMode}, 8'h00);
		tend("reset");
		for (int i = 0; i < 66; i++) dat[i] = 8'($urandom);
		for (int i = 0; i < 66; i++) pg[(i + 'h3e) % 64] = dat[i];
		cmd(8'h06);
		wr(16'hc13e, 66, 8'h02);
		u_host.stop();
		rdst(8'h00);
		wr(16'h4100, 0, 8'h03);
		for (int i = 0; i < 64; i++) rd(pg[i]);
		u_host.stop();
		tend("page");
		for (int i = 0; i < 2; i++) begin
			cmd(8'h06);
			dat[0] = i ? 8'ha5 : 8'h5a;
			wr(i ? 16'h0000 : 16'h3fff, 1, 8'h02);
			u_host.stop();
			idle();
		end
		cmd(8'h06);
		wr(16'h1fff, 1, 8'h02);
		u_host.stop();
		wr(16'h0000, 0, 8'h03);
		u_host.xb(8'h00, 8);
		u_host.stop();
		chk({7'h00, u_host.oeAny}, 8'h00);
		idle();
		wr(16'h3fff, 0, 8'h03);
		rd(8'h5a);
		u_host.pause(1'b0);
		chk({7'h00, u_host.oeAny}, 8'h00);
		rd(8'ha5);
		u_host.stop();
		u_host.go();
		u_host.xb(8'hb7, 8);
		u_host.xb(8'h05, 8);
		u_host.stop();
		chk({7'h00, u_host.oeAny}, 8'h00);
		tend("read");
		dat[0] = 8'h33;
		wr(16'h0000, 1, 8'h02);
		u_host.stop();
		cmd(8'h06);
		wr(16'h0000, 1, 8'h02);
		u_host.xb(8'h0f, 7);
		u_host.stop();
		rdst(8'h02);
		cmd(8'h04);
		rdst(8'h00);
		wr(16'h0000, 0, 8'h03);
		rd(8'ha5);
		u_host.stop();
		tend("refuse");
		for (int g = 0; g < 4; g++) begin
			cmd(8'h06);
			cmd(8'h01, 8'(g << 2), 1'b1);
			rdst(8'(g << 2));
			for (int k = 0; k < 4; k++) begin
				cmd(8'h06);
				wr(16'(ad[k]), 1, 8'h02);
				u_host.stop();
				rdst(8'(g << 2) | (ad[k] >= lo[g] ? 8'h02 : 8'h00));
			end
		end
		tend("guard");
		cmd(8'h06);
		cmd(8'h01, 8'h80, 1'b1);
		idle();
		pin(1'b0);
		chk({7'h00, hwGuardMode}, 8'h01);
		cmd(8'h06);
		cmd(8'h01, 8'h0c, 1'b1);
		rdst(8'h82);
		wr(16'h0000, 1, 8'h02);
		u_host.stop();
		rdst(8'h80);
		pin(1'b1);
		chk({7'h00, hwGuardMode}, 8'h00);
		cmd(8'h06);
		cmd(8'h01, 8'h00, 1'b1);
		rdst(8'h00);
		tend("hardware");
		cmd(8'h06);
		wr(16'h0000, 1, 8'h02);
		u_host.stop();
		@(posedge mclk);
		#1 lowSupply = 1'b1;
		@(posedge mclk);
		#1 lowSupply = 1'b0;
		repeat (4) @(posedge mclk);
		chk({3'b000, status}, 8'h00);
		cmd(8'h06);
		wr(16'h0000, 1, 8'h02);
		u_host.pause(1'b1);
		rdst(8'h02);
		tend("cancel");
		print_verdict();
	end
endmodule
`default_nettype wire
